/* hdl/cswr_clock_switch.sv */
// clock switch controller with reference clock divider and apb registers
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cswr_consts.svh"
// ============================================================
module cswr_clock_switch #(
  parameter int DIV_W = 15 // reference divider counter width
) (
  input wire logic i_clk, // system clock 250 mhz
  input wire logic i_rst_b, // synchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error on unmapped address
  input wire logic i_switch_enable_cfg, // low enables switching
  input wire logic i_failsafe_cfg, // fail-safe monitor configured
  input wire logic [2:0] i_initial_source_cfg, // power-on source
  input wire logic [1:0] i_primary_submode_cfg, // primary submode, fixed
  input wire logic i_sleep, // device in sleep
  input wire logic i_low_power_rc_needed, // watchdog, monitor or calendar uses low_power_rc
  input wire logic i_clock_fail, // monitor detected failure pulse
  input wire logic i_osc_startup_done, // oscillator start-up timer pin
  input wire logic i_pll_lock, // pll lock pin
  input wire logic i_new_clk_tick, // new source clock level, async
  input wire logic i_primary_clk, // primary oscillator level, async
  output logic [2:0] o_sys_source, // system clock source select
  output logic [7:0] o_osc_power, // per source run enable
  output logic o_ref_clock_pin, // reference clock pin level
  output logic o_ref_clock_oe, // reference pin output enable
  output logic o_half_rate_clock_out // half rate clock output
);
  // ============================================================
  // state record
  typedef struct packed {
    cswr_pkg::cswr_state_t st; // switch sequencer state
    cswr_pkg::cswr_unlock_t unl_hi; // high byte unlock progress
    cswr_pkg::cswr_unlock_t unl_lo; // low byte unlock progress
    logic init_done; // config captured after reset
    logic [2:0] cur_src; // current source
    logic [2:0] new_src; // new source selection
    logic [2:0] old_src; // source being left
    logic sel_lock; // selection lock
    logic pll_locked; // pll lock status
    logic fail; // clock fail flag
    logic sec_en; // secondary oscillator enable
    logic req; // switch request
    logic [15:0] ref_ctrl; // reference clock control
    logic [3:0] settle; // new clock edges counted
    logic [2:0] tick_sync; // new clock synchroniser
    logic [2:0] pri_sync; // primary clock synchroniser
    logic [DIV_W-1:0] ref_cnt; // reference divider counter
    logic ref_out; // reference output level
    logic half; // half rate output
    logic [31:0] rdata; // registered read data
  } cswr_regs_t;

  cswr_regs_t r; // current state
  cswr_regs_t next_r; // next state

  // ============================================================
  // helper decoding
  // three bit source codes, pll codes 001 and 011, primary 010 and 011
  function automatic logic is_pll(input logic [2:0] s);
    is_pll = (s == `CSWR_SRC_FRC_PLL) || (s == `CSWR_SRC_PRI_PLL);
  endfunction
  function automatic logic is_pri(input logic [2:0] s);
    is_pri = (s == `CSWR_SRC_PRI) || (s == `CSWR_SRC_PRI_PLL);
  endfunction

  logic sw_en; // switching allowed
  logic wr_acc; // apb write access phase
  logic rd_acc; // apb read access phase
  logic acc; // any access phase
  logic mapped; // address decodes
  logic osc_wr; // write access to oscillator control
  logic tick_rise; // agreed rising edge of new clock
  logic base_rise; // reference base edge
  logic ref_run; // reference divider allowed to run
  logic [3:0] div_shift; // counter stages used by the selected code
  logic [DIV_W:0] div_mask; // divider terminal mask
  logic [15:0] osc_view; // oscillator control readback

  assign sw_en = !i_switch_enable_cfg;
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign mapped = (paddr == `CSWR_ADDR_OSC_CTRL) || (paddr == `CSWR_ADDR_REF_CTRL) ||
                  (paddr == `CSWR_ADDR_STATUS);
  assign osc_wr = wr_acc && (paddr == `CSWR_ADDR_OSC_CTRL);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = r.rdata;
  // edge counts once the second stage is high and the third stage is still low
  // stage zero may go metastable and is read by nothing but stage one
  assign tick_rise = r.tick_sync[1] && r.tick_sync[2] == 1'b0 ? 1'b1 : 1'b0;
  assign base_rise = r.ref_ctrl[`CSWR_REF_SEL_BIT] ? (r.pri_sync[1] && !r.pri_sync[2]) : 1'b1;
  // sleep gating of the reference output
  assign ref_run = r.ref_ctrl[`CSWR_REF_EN_BIT] && (!i_sleep ||
                   (r.ref_ctrl[`CSWR_REF_SLP_BIT] && r.ref_ctrl[`CSWR_REF_SEL_BIT] && is_pri(r.cur_src)));
  // power of two divider terminal, code n from one up gives 2^n
  // code n needs a toggle every 2^(n-1) base edges, so the terminal count uses
  // one stage less than the code; code zero and code one both toggle on every
  // base edge of the system clock, and code zero on the primary base bypasses
  // the counter altogether
  assign div_shift = (r.ref_ctrl[`CSWR_REF_DIV_LSB +: 4] == 4'h0) ? 4'h0 :
                     r.ref_ctrl[`CSWR_REF_DIV_LSB +: 4] - 4'h1;
  assign div_mask = ((DIV_W+1)'(1) << div_shift) - (DIV_W+1)'(1);
  // lock bit reads zero for non-pll source
  assign osc_view = {1'b0, r.cur_src, 1'b0, r.new_src, r.sel_lock, 1'b0,
                     r.pll_locked && is_pll(r.cur_src), 1'b0, r.fail, 1'b0, r.sec_en, r.req};

  // ============================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.tick_sync = {r.tick_sync[1:0], i_new_clk_tick};
    next_r.pri_sync = {r.pri_sync[1:0], i_primary_clk};
    // capture straps after reset release
    if (!r.init_done) begin
      next_r.init_done = 1'b1;
      next_r.cur_src = i_initial_source_cfg;
      next_r.new_src = i_initial_source_cfg;
      next_r.old_src = i_initial_source_cfg;
    end
    if (!sw_en) begin
      next_r.cur_src = i_initial_source_cfg;
    end
    if (i_pll_lock) begin
      next_r.pll_locked = 1'b1;
    end
    // fail flag set by monitor, only when monitor is active
    if (i_clock_fail && i_failsafe_cfg && sw_en) begin
      next_r.fail = 1'b1;
    end
    // ============================================================
    // register writes, unlock sequencing on oscillator control only
    // each byte lane has its own key tracker; a lane only opens after both keys
    // arrive in consecutive access phases, and an opened lane closes after the
    // next access whatever it was, so a stray read between keys also relocks
    if (osc_wr && pstrb[1]) begin
      case (r.unl_hi)
        cswr_pkg::CSWR_UNL_NONE: begin
          next_r.unl_hi = (pwdata[15:8] == `CSWR_KEY_HI_1) ? cswr_pkg::CSWR_UNL_KEY1 : cswr_pkg::CSWR_UNL_NONE;
        end
        cswr_pkg::CSWR_UNL_KEY1: begin
          next_r.unl_hi = (pwdata[15:8] == `CSWR_KEY_HI_2) ? cswr_pkg::CSWR_UNL_OPEN : cswr_pkg::CSWR_UNL_NONE;
        end
        cswr_pkg::CSWR_UNL_OPEN: begin
          if (!(r.sel_lock && i_failsafe_cfg)) begin
            next_r.new_src = pwdata[`CSWR_NEW_LSB +: 3];
          end
          next_r.unl_hi = cswr_pkg::CSWR_UNL_NONE;
        end
        default: begin
          next_r.unl_hi = cswr_pkg::CSWR_UNL_NONE;
        end
      endcase
    end else if (acc) begin
      // any other access expires the unlock
      next_r.unl_hi = cswr_pkg::CSWR_UNL_NONE;
    end
    if (osc_wr && pstrb[0]) begin
      case (r.unl_lo)
        cswr_pkg::CSWR_UNL_NONE: begin
          next_r.unl_lo = (pwdata[7:0] == `CSWR_KEY_LO_1) ? cswr_pkg::CSWR_UNL_KEY1 : cswr_pkg::CSWR_UNL_NONE;
        end
        cswr_pkg::CSWR_UNL_KEY1: begin
          next_r.unl_lo = (pwdata[7:0] == `CSWR_KEY_LO_2) ? cswr_pkg::CSWR_UNL_OPEN : cswr_pkg::CSWR_UNL_NONE;
        end
        cswr_pkg::CSWR_UNL_OPEN: begin
          next_r.unl_lo = cswr_pkg::CSWR_UNL_NONE;
          next_r.sec_en = pwdata[`CSWR_SEC_EN_BIT];
          // selection lock is set only
          if (pwdata[`CSWR_LOCK_BIT]) begin
            next_r.sel_lock = 1'b1;
          end
          // fail flag is clear only; a new failure wins
          if (!pwdata[`CSWR_FAIL_BIT] && !(i_clock_fail && i_failsafe_cfg && sw_en)) begin
            next_r.fail = 1'b0;
          end
          // request ignored while disabled, or locked with fail-safe configured
          if (pwdata[`CSWR_REQ_BIT] && sw_en && !(r.sel_lock && i_failsafe_cfg)) begin
            next_r.req = 1'b1;
          end
        end
        default: begin
          next_r.unl_lo = cswr_pkg::CSWR_UNL_NONE;
        end
      endcase
    end else if (acc) begin
      // any other access expires the unlock
      next_r.unl_lo = cswr_pkg::CSWR_UNL_NONE;
    end
    if (wr_acc && paddr == `CSWR_ADDR_REF_CTRL) begin
      // reserved bits stay zero
      if (pstrb[1]) begin
        next_r.ref_ctrl[15:8] = pwdata[15:8] & 8'hBF;
      end
    end
    // ============================================================
    // switch sequencer, processor never stalled
    // the bus stays live in every state, so software may poll the request bit
    // while the new source starts; the request bit stays set until the
    // sequencer finishes the changeover, aborts a redundant switch or switching is disabled
    case (r.st)
      cswr_pkg::CSWR_IDLE: begin
        if (r.req && r.init_done) begin
          if (r.new_src == r.cur_src) begin
            next_r.req = 1'b0;
          end else begin
            // clear lock and fail at valid start
            next_r.pll_locked = 1'b0;
            next_r.fail = 1'b0;
            next_r.old_src = r.cur_src;
            next_r.settle = 4'h0;
            next_r.st = cswr_pkg::CSWR_START;
          end
        end
      end
      cswr_pkg::CSWR_START: begin
        // wait start-up timer for primary and pll lock for pll sources
        if ((!is_pri(r.new_src) || i_osc_startup_done) && (!is_pll(r.new_src) || i_pll_lock)) begin
          next_r.st = cswr_pkg::CSWR_SETTLE;
        end
      end
      cswr_pkg::CSWR_SETTLE: begin
        if (tick_rise) begin
          next_r.settle = r.settle + 4'h1;
          if (r.settle == `CSWR_SETTLE_CYCLES - 4'h1) begin
            next_r.cur_src = r.new_src;
            next_r.req = 1'b0;
            next_r.st = cswr_pkg::CSWR_IDLE;
          end
        end
      end
      default: begin
        next_r.st = cswr_pkg::CSWR_IDLE;
      end
    endcase
    // request held at zero while disabled
    // this override comes last so no path above can leave a request standing
    if (!sw_en) begin
      next_r.req = 1'b0;
      next_r.st = cswr_pkg::CSWR_IDLE;
    end
    // ============================================================
    // reference divider
    // the pin toggles once every 2^(n-1) base edges for code n, so one full
    // output period spans 2^n base periods
    if (!ref_run) begin
      next_r.ref_cnt = '0;
      next_r.ref_out = 1'b0;
    end else if (r.ref_ctrl[`CSWR_REF_SEL_BIT] && r.ref_ctrl[`CSWR_REF_DIV_LSB +: 4] == 4'h0) begin
      // code zero on the primary base follows its synchronised level
      next_r.ref_cnt = '0;
      next_r.ref_out = r.pri_sync[1];
    end else if (base_rise) begin
      // code zero on the system clock toggles each edge, the fastest a flop gives
      if (({1'b0, r.ref_cnt} & div_mask) == div_mask) begin
        next_r.ref_cnt = '0;
        next_r.ref_out = !r.ref_out;
      end else begin
        next_r.ref_cnt = r.ref_cnt + DIV_W'(1);
      end
    end
    // half rate output in internal and primary modes
    // it is the system clock divided by two, held low on the secondary source
    next_r.half = (r.cur_src != `CSWR_SRC_SEC) ? !r.half : 1'b0;
    // read data capture
    // data is latched in the setup cycle so prdata is a flop output that stands
    // for the whole access phase; between transfers it returns to zero
    next_r.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `CSWR_ADDR_OSC_CTRL: next_r.rdata = {16'h0000, osc_view};
        `CSWR_ADDR_REF_CTRL: next_r.rdata = {16'h0000, r.ref_ctrl};
        `CSWR_ADDR_STATUS: next_r.rdata = {29'h0000_0000, r.st};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end else if (rd_acc) begin
      next_r.rdata = r.rdata;
    end
  end

  // ============================================================
  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      r <= '0;
      r.ref_ctrl <= `CSWR_REF_CTRL_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ============================================================
  // oscillator power, old source off unless still needed
  // the enables are combinational from registered state, so the previous source
  // drops in the same cycle that the current field moves over
  always_comb begin
    o_osc_power = 8'h00;
    o_osc_power[r.cur_src] = 1'b1;
    if (r.st != cswr_pkg::CSWR_IDLE) begin
      o_osc_power[r.new_src] = 1'b1;
    end
    if (i_low_power_rc_needed) begin
      o_osc_power[`CSWR_SRC_LOW_POWER_RC] = 1'b1;
    end
    if (r.sec_en) begin
      o_osc_power[`CSWR_SRC_SEC] = 1'b1;
    end
    // primary off in sleep unless the enabled reference selects it
    if (i_sleep && !(r.ref_ctrl[`CSWR_REF_SEL_BIT] && r.ref_ctrl[`CSWR_REF_EN_BIT])) begin
      o_osc_power[`CSWR_SRC_PRI] = 1'b0;
      o_osc_power[`CSWR_SRC_PRI_PLL] = 1'b0;
    end
  end

  // primary submode input is not used; the outputs below come straight from registered state
  assign o_ref_clock_pin = r.ref_out;
  assign o_ref_clock_oe = r.ref_ctrl[`CSWR_REF_EN_BIT];
  assign o_sys_source = r.cur_src;
  assign o_half_rate_clock_out = r.half;
endmodule

/* common/cswr_consts.svh */
// constants for the clock switch and reference output block
`ifndef CSWR_CONSTS_SVH
`define CSWR_CONSTS_SVH
// ============================================================
// register byte addresses
`define CSWR_ADDR_OSC_CTRL 12'h000
`define CSWR_ADDR_REF_CTRL 12'h004
`define CSWR_ADDR_STATUS 12'h008
// ============================================================
// unlock keys
`define CSWR_KEY_HI_1 8'h78
`define CSWR_KEY_HI_2 8'h9A
`define CSWR_KEY_LO_1 8'h46
`define CSWR_KEY_LO_2 8'h57
// ============================================================
// source codes
`define CSWR_SRC_FRC 3'h0
`define CSWR_SRC_FRC_PLL 3'h1
`define CSWR_SRC_PRI 3'h2
`define CSWR_SRC_PRI_PLL 3'h3
`define CSWR_SRC_SEC 3'h4
`define CSWR_SRC_LOW_POWER_RC 3'h5
`define CSWR_SRC_LPFRC_DIV 3'h6
`define CSWR_SRC_FRC_DIV 3'h7
// ============================================================
// field positions
`define CSWR_CUR_LSB 12
`define CSWR_NEW_LSB 8
`define CSWR_LOCK_BIT 7
`define CSWR_PLL_LOCK_BIT 5
`define CSWR_FAIL_BIT 3
`define CSWR_SEC_EN_BIT 1
`define CSWR_REQ_BIT 0
`define CSWR_REF_EN_BIT 15
`define CSWR_REF_SLP_BIT 13
`define CSWR_REF_SEL_BIT 12
`define CSWR_REF_DIV_LSB 8
// ============================================================
// timing: settle count in new-clock cycles
`define CSWR_SETTLE_CYCLES 4'hA
`define CSWR_REF_CTRL_RESET 16'h0000
`endif

/* common/cswr_pkg.sv */
// types for the clock switch and reference output block
package cswr_pkg;
  typedef enum logic [2:0] {
    CSWR_IDLE,
    CSWR_START,
    CSWR_SETTLE
  } cswr_state_t;
  typedef enum logic [1:0] {
    CSWR_UNL_NONE,
    CSWR_UNL_KEY1,
    CSWR_UNL_OPEN
  } cswr_unlock_t;
endpackage

/* test/cswr_clock_switch_properties.sv */
// port checker for the clock switch block
`timescale 1ns/1ps
`include "cswr_consts.svh"
// ============================================================
// checker module
module cswr_clock_switch_chk (
  input wire logic i_clk, // clock
  input wire logic i_rst_b, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb strobes
  input wire logic pready, // apb ready
  input wire logic [31:0] prdata, // apb read data
  input wire logic pslverr, // apb error
  input wire logic i_switch_enable_cfg, // high blocks switching
  input wire logic [2:0] i_initial_source_cfg, // power-on source
  input wire logic i_sleep, // sleep
  input wire logic [2:0] o_sys_source, // current source
  input wire logic [7:0] o_osc_power, // run enables
  input wire logic o_ref_clock_oe, // reference enable
  input wire logic o_half_rate_clock_out // half rate clock
);
  logic acc; // access phase
  logic rd_osc; // oscillator control read in access phase
  logic mapped; // address is one of the three registers
  assign acc = psel && penable;
  assign mapped = paddr inside {`CSWR_ADDR_OSC_CTRL, `CSWR_ADDR_REF_CTRL, `CSWR_ADDR_STATUS};
  assign rd_osc = acc && !pwrite && paddr == `CSWR_ADDR_OSC_CTRL;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ============================================================
  // bus answers
  pready_high_a: assert property (acc |-> pready) else $error("pready low in access");
  bad_addr_a: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
  good_addr_a: assert property (acc && mapped |-> !pslverr) else $error("error on mapped");
  prdata_idle_a: assert property (!psel && !$past(psel) |-> prdata == 32'h0) else $error("prdata not idle");
  // ============================================================
  // switching and outputs
  ref_enable_a: assert property (
    acc && pwrite && paddr == `CSWR_ADDR_REF_CTRL && pstrb[1] |=> o_ref_clock_oe == $past(pwdata[15]))
    else $error("ref enable not written");
  fixed_src_a: assert property (
    i_switch_enable_cfg && $past(i_rst_b, 2) |-> o_sys_source == i_initial_source_cfg)
    else $error("source moved while disabled");
  req_held_a: assert property (rd_osc && i_switch_enable_cfg |-> !prdata[0]) else $error("request set");
  pll_lock_a: assert property (
    rd_osc && !(prdata[14:12] inside {`CSWR_SRC_FRC_PLL, `CSWR_SRC_PRI_PLL}) |-> !prdata[5])
    else $error("lock set without pll");
  half_rate_a: assert property (
    $past(i_rst_b, 2) && o_sys_source != `CSWR_SRC_SEC && $past(o_sys_source) != `CSWR_SRC_SEC
    |-> o_half_rate_clock_out != $past(o_half_rate_clock_out)) else $error("half rate stuck");
  src_power_a: assert property ($past(i_rst_b, 2) && !i_sleep |-> o_osc_power[o_sys_source])
    else $error("current source unpowered");
endmodule
bind cswr_clock_switch cswr_clock_switch_chk chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .i_switch_enable_cfg(i_switch_enable_cfg),
  .i_initial_source_cfg(i_initial_source_cfg), .i_sleep(i_sleep), .o_sys_source(o_sys_source),
  .o_osc_power(o_osc_power), .o_ref_clock_oe(o_ref_clock_oe), .o_half_rate_clock_out(o_half_rate_clock_out));

/* test/cswr_osc_model.sv */
// oscillator sources feeding the clock switch block
`timescale 1ns/1ps
// ============================================================
// oscillator model
module cswr_osc_model #(
  parameter int START_CYC = 20 // start-up and lock delay in system clocks
) (
  input wire logic i_clk, // system clock
  input wire logic [7:0] i_osc_power, // run enables
  output logic o_new_clk, // new source clock
  output logic o_primary_clk, // primary oscillator clock
  output logic o_startup_done, // start-up timer expired
  output logic o_pll_lock // pll locked
);
  int pri_cnt = 0; // cycles primary has run
  int pll_cnt = 0; // cycles pll has run
  initial o_new_clk = 1'b0;
  initial o_primary_clk = 1'b0;
  // free clocks, phase unrelated to the system clock; primary stops when unpowered
  always #7 o_new_clk = !o_new_clk;
  always #11 o_primary_clk = (i_osc_power[2] | i_osc_power[3]) ? !o_primary_clk : o_primary_clk;
  always @(posedge i_clk) begin
    pri_cnt <= (i_osc_power[2] | i_osc_power[3]) ? pri_cnt + 1 : 0;
    pll_cnt <= (i_osc_power[1] | i_osc_power[3]) ? pll_cnt + 1 : 0;
  end
  assign o_startup_done = pri_cnt >= START_CYC;
  assign o_pll_lock = pll_cnt >= START_CYC;
endmodule

/* test/cswr_clock_switch_tb.sv */
// self-checking bench for the clock switch block
`timescale 1ns/1ps
`include "cswr_consts.svh"
// ============================================================
// bench top
module cswr_clock_switch_tb;
  localparam logic [11:0] osc_a = `CSWR_ADDR_OSC_CTRL; // oscillator control
  localparam logic [11:0] ref_a = `CSWR_ADDR_REF_CTRL; // reference control
  logic i_clk = 1'b0; // system clock
  logic i_rst_b = 1'b0; // reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err; // apb controls
  logic [11:0] paddr = 12'h000; // apb address
  logic [31:0] pwdata = 32'h0, prdata, rd; // apb data, last read
  logic [3:0] pstrb = 4'h0; // apb strobes
  logic cfg_dis = 1'b0, fsafe = 1'b1, sleep = 1'b0, low_power_rc = 1'b0, cfail = 1'b0; // config and status
  logic [2:0] init_src = 3'h0, sys_src; // power-on and current source
  // fast rc stands between the two pll modes
  logic [2:0] seq [9] = '{3'h3, 3'h0, 3'h1, 3'h0, 3'h4, 3'h5, 3'h7, 3'h6, 3'h0}; // switch order
  logic [7:0] power; // run enables
  logic nclk, pclk, sdone, lock, ref_pin, ref_oe; // oscillator and output pins
  int miscompares = 0, total_checks = 0, t, n; // counters
  always #2 i_clk = !i_clk;
  cswr_clock_switch uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .i_switch_enable_cfg(cfg_dis), .i_failsafe_cfg(fsafe), .i_initial_source_cfg(init_src),
    .i_primary_submode_cfg(2'h1), .i_sleep(sleep), .i_low_power_rc_needed(low_power_rc), .i_clock_fail(cfail),
    .i_osc_startup_done(sdone), .i_pll_lock(lock), .i_new_clk_tick(nclk), .i_primary_clk(pclk),
    .o_sys_source(sys_src), .o_osc_power(power), .o_ref_clock_pin(ref_pin), .o_ref_clock_oe(ref_oe),
    .o_half_rate_clock_out());
  cswr_osc_model #(.START_CYC(20)) osc (.i_clk(i_clk), .i_osc_power(power), .o_new_clk(nclk),
    .o_primary_clk(pclk), .o_startup_done(sdone), .o_pll_lock(lock));
  // ============================================================
  // tasks
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, answer taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge i_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 50) begin
      miscompares++;
      conclude;
    end
  endtask
  // keyed new source write, then keyed low byte write
  // the six writes follow one another, one idle cycle apart, with no other access in between
  task automatic switch_to(input logic [2:0] src, input logic [7:0] lo);
    apb(1'b1, osc_a, 32'h7800, 4'h2);
    apb(1'b1, osc_a, 32'h9A00, 4'h2);
    apb(1'b1, osc_a, {21'h0, src, 8'h00}, 4'h2);
    apb(1'b1, osc_a, 32'h46, 4'h1);
    apb(1'b1, osc_a, 32'h57, 4'h1);
    apb(1'b1, osc_a, {24'h0, lo}, 4'h1);
  endtask
  // poll the request bit until it clears
  // request polled first, lock bit looked at from the same read
  task automatic wait_done;
    n = 0;
    do begin
      apb(1'b0, osc_a, 32'h0, 4'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    if (n == 200) begin
      miscompares++;
      conclude;
    end
  endtask
  // cycles between two changes of the reference pin
  task automatic half_period;
    logic v;
    @(posedge i_clk);
    v = ref_pin;
    for (n = 0; n < 99 && ref_pin === v; n++) @(posedge i_clk);
    v = ref_pin;
    for (t = 0; t < 99 && ref_pin === v; t++) @(posedge i_clk);
  endtask
  // ============================================================
  // main sequence
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    apb(1'b0, osc_a, 32'h0, 4'h0);
    check("osc reset", 32'h0, rd);
    apb(1'b0, ref_a, 32'h0, 4'h0);
    check("ref reset", 32'h0, rd);
    apb(1'b0, 12'h00C, 32'h0, 4'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, osc_a, 32'h0200, 4'h2);
    apb(1'b0, osc_a, 32'h0, 4'h0);
    check("unkeyed write", 32'h0, rd);
    apb(1'b1, osc_a, 32'h7800, 4'h2);
    apb(1'b1, osc_a, 32'h9A00, 4'h2);
    apb(1'b0, osc_a, 32'h0, 4'h0);
    apb(1'b1, osc_a, 32'h0200, 4'h2);
    apb(1'b0, osc_a, 32'h0, 4'h0);
    check("expired unlock", 32'h0, rd);
    cfail <= 1'b1;
    @(posedge i_clk);
    cfail <= 1'b0;
    apb(1'b0, osc_a, 32'h0, 4'h0);
    check("fail flag", 32'h1, {31'h0, rd[3]});
    switch_to(3'h2, 8'h09);
    apb(1'b0, osc_a, 32'h0, 4'h0);
    check("switch start", 32'h1, {29'h0, rd[5], rd[3], rd[0]});
    check("old source kept", 32'h0, {29'h0, sys_src});
    wait_done;
    check("current field", 32'h2, {29'h0, rd[14:12]});
    switch_to(3'h2, 8'h01);
    wait_done;
    check("redundant abort", 32'h1, {31'h0, n <= 2});
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ref_a, {16'h0, 4'h8, k[3:0], 8'h00}, 4'h2);
      @(posedge i_clk);
      check("ref enable", 32'h1, {31'h0, ref_oe});
      half_period;
      check("ref divide", (k == 0) ? 32'h1 : 32'h1 << (k - 1), t);
    end
    apb(1'b1, ref_a, 32'h9000, 4'h2);
    half_period;
    check("ref on primary", 32'h1, {31'h0, t >= 2 && t <= 3});
    apb(1'b1, ref_a, 32'h0000, 4'h2);
    @(posedge i_clk);
    check("ref disabled", 32'h0, {31'h0, ref_oe});
    foreach (seq[i]) begin
      switch_to(seq[i], 8'h01);
      wait_done;
      check("system source", {29'h0, seq[i]}, {29'h0, sys_src});
      check("source power", 32'h1 << seq[i], {24'h0, power});
      check("pll lock", {31'h0, seq[i] == 3'h1 || seq[i] == 3'h3}, {31'h0, rd[5]});
    end
    i_rst_b <= 1'b0;
    cfg_dis <= 1'b1;
    init_src <= 3'h5;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    switch_to(3'h0, 8'h01);
    apb(1'b0, osc_a, 32'h0, 4'h0);
    check("request held", 32'h0, {31'h0, rd[0]});
    check("config source", 32'h5, {29'h0, rd[14:12]});
    check("source fixed", 32'h5, {29'h0, sys_src});
    conclude;
  end
endmodule
